// ==== logic/ffc_map.svh ====
/*
 fill/transmit/lock configuration block: register indices, bit positions and reset values.
 assumes a 32-bit bus where each register index maps to byte address index * 4.
*/
`ifndef FFC_MAP_SVH
`define FFC_MAP_SVH

// register indices, byte address is index * 4
`define FFC_CFG_IDX    6'h0e
`define FFC_STAT_IDX   6'h10
`define FFC_CLR_IDX    6'h11
`define FFC_EN_IDX     6'h12

// configuration register bit positions
`define FFC_B_FM       7
`define FFC_B_FSC      6
`define FFC_B_TXD      5
`define FFC_B_TXS      4
`define FFC_B_RESV     3
`define FFC_B_RIRQ     2
`define FFC_B_LST      1
`define FFC_B_LEN      0

// reset values
`define FFC_CFG_RST    8'h01
`define FFC_EVT_RST    4'h0

`endif

// ==== logic/ffc_pkg.sv ====
/*
 types shared by the fill/transmit/lock configuration block.
 assumes ffc_map.svh carries all numeric constants.
*/
package ffc_pkg;

   // fill engine state
   typedef enum logic {FILL_IDLE, FILL_ACTIVE} ffc_fill_e;

   // register selected by an address
   typedef enum logic [2:0] {SEL_CFG, SEL_STAT, SEL_CLR, SEL_EN, SEL_NONE} ffc_sel_e;

   // software-owned configuration fields
   typedef struct packed {
      logic fill_method;
      logic tx_irq0_sel;
      logic resv;
      logic rssi_en;
      logic lock_en;
   } ffc_cfg_s;

   // sticky event bits, same layout in status, clear and enable
   typedef struct packed {
      logic rssi;
      logic lock;
      logic fill_done;
      logic tx_done;
   } ffc_evt_s;

endpackage

// ==== logic/ffc_sync.sv ====
/*
 three-stage synchroniser for asynchronous inputs.
 assumes a free-running clock; output follows once stages two and three agree.
*/
`timescale 1ns/1ns
module ffc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset_n,
   // async in, synchronous out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   generate
      if (WIDTH < 1) begin : g_chk
         $error("ffc_sync: WIDTH must be at least 1");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic next_out;
         // stage one is read only by stage two
         always_comb begin
            next_out = (s2 == s3) ? s3 : sync_out[i];
         end
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               s1          <= 1'b0;
               s2          <= 1'b0;
               s3          <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               s1          <= async_in[i];
               s2          <= s1;
               s3          <= s2;
               sync_out[i] <= next_out;
            end
         end
      end
   endgenerate

endmodule

// ==== logic/ffc_top.sv ====
/*
 fifo fill control, transmit-complete flag, lock status and signal-strength gating,
 with one configuration register and an interrupt block on an APB slave.
 assumes event inputs come from logic on the same clock, except the lock level,
 which arrives asynchronously from the synthesiser.
*/
`timescale 1ns/1ns
`include "ffc_map.svh"
module ffc_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // apb slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // datapath events
   input  wire logic              sync_word_seen,
   input  wire logic              fill_complete,
   input  wire logic              tx_begin,
   input  wire logic              tx_last_bit_out,
   input  wire logic              rssi_cross,
   input  wire logic              lock_detect_raw,
   // control outputs
   output logic                   fifo_fill_active,
   output logic                   fill_method_select,
   output logic                   tx_start_on_first_irq_sel,
   output logic                   lock_detect_enable,
   output logic                   rssi_irq_source,
   output logic                   irq
);

   generate
      if (ADDR_W < 8) begin : g_chk
         $error("ffc_top: ADDR_W must be at least 8");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // address decode, used for both read and write
   function automatic ffc_pkg::ffc_sel_e decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] base;
      base = a & ~ADDR_W'(3);
      if (base == ADDR_W'({`FFC_CFG_IDX, 2'b00}))
         return ffc_pkg::SEL_CFG;
      else if (base == ADDR_W'({`FFC_STAT_IDX, 2'b00}))
         return ffc_pkg::SEL_STAT;
      else if (base == ADDR_W'({`FFC_CLR_IDX, 2'b00}))
         return ffc_pkg::SEL_CLR;
      else if (base == ADDR_W'({`FFC_EN_IDX, 2'b00}))
         return ffc_pkg::SEL_EN;
      else
         return ffc_pkg::SEL_NONE;
   endfunction

   ffc_pkg::ffc_cfg_s  cfg;
   ffc_pkg::ffc_cfg_s  next_cfg;
   ffc_pkg::ffc_fill_e fill_state;
   ffc_pkg::ffc_fill_e next_fill_state;
   ffc_pkg::ffc_evt_s  status;
   ffc_pkg::ffc_evt_s  next_status;
   ffc_pkg::ffc_evt_s  enable;
   ffc_pkg::ffc_evt_s  next_enable;
   ffc_pkg::ffc_evt_s  evt;
   logic               tx_flag;
   logic               next_tx_flag;
   logic               lock_flag;
   logic               next_lock_flag;
   logic               lock_sync;
   logic               lock_good;
   logic               lock_good_d;
   logic               next_rssi_src;
   logic [31:0]        next_prdata;
   logic               next_pslverr;
   logic               wr;
   logic               wr_cfg;
   logic [7:0]         cfg_view;

   // reset image of the software fields, cut from the register reset value
   localparam logic [7:0] CFG_RST = `FFC_CFG_RST;
   localparam ffc_pkg::ffc_cfg_s CFG_INIT = {CFG_RST[`FFC_B_FM], CFG_RST[`FFC_B_TXS],
                                            CFG_RST[`FFC_B_RESV], CFG_RST[`FFC_B_RIRQ],
                                            CFG_RST[`FFC_B_LEN]};
   ////////////////////////////////////////////////////////////////////////////
   // lock level comes from another clock domain
   ffc_sync #(.WIDTH(1)) u_lock_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in (lock_detect_raw),
      .sync_out (lock_sync)
   );

   // zero-wait slave: read data is captured in setup, so access never stalls
   assign pready = psel & penable;
   assign wr     = psel & penable & pwrite;
   assign wr_cfg = wr & (decode(paddr) == ffc_pkg::SEL_CFG) & pstrb[0];
   // detection runs only while enabled
   assign lock_good = cfg.lock_en & lock_sync;

   // readable view of the configuration register
   assign cfg_view = {cfg.fill_method, fifo_fill_active, tx_flag, cfg.tx_irq0_sel,
                      cfg.resv, cfg.rssi_en, lock_flag, cfg.lock_en};

   assign fill_method_select        = cfg.fill_method;
   assign tx_start_on_first_irq_sel = cfg.tx_irq0_sel;
   assign lock_detect_enable        = cfg.lock_en;
   assign fifo_fill_active          = (fill_state == ffc_pkg::FILL_ACTIVE);

   ////////////////////////////////////////////////////////////////////////////
   // fill engine
   always_comb begin
      next_fill_state = fill_state;
      unique case (fill_state)
         ffc_pkg::FILL_IDLE: begin
            if (!cfg.fill_method && sync_word_seen)
               next_fill_state = ffc_pkg::FILL_ACTIVE;
            else if (cfg.fill_method && wr_cfg && pwdata[`FFC_B_FSC])
               next_fill_state = ffc_pkg::FILL_ACTIVE;
         end
         ffc_pkg::FILL_ACTIVE: begin
            // completion wins over a manual write in the same cycle
            if (fill_complete)
               next_fill_state = ffc_pkg::FILL_IDLE;
            else if (cfg.fill_method && wr_cfg && !pwdata[`FFC_B_FSC])
               next_fill_state = ffc_pkg::FILL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         fill_state <= ffc_pkg::FILL_IDLE;
      else
         fill_state <= next_fill_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration fields and flags
   always_comb begin
      next_cfg = cfg;
      if (wr_cfg) begin
         next_cfg.fill_method = pwdata[`FFC_B_FM];
         next_cfg.tx_irq0_sel = pwdata[`FFC_B_TXS];
         next_cfg.resv        = pwdata[`FFC_B_RESV];
         next_cfg.rssi_en     = pwdata[`FFC_B_RIRQ];
         next_cfg.lock_en     = pwdata[`FFC_B_LEN];
      end
      // last bit out sets, a new transmission clears
      if (tx_last_bit_out)
         next_tx_flag = 1'b1;
      else if (tx_begin)
         next_tx_flag = 1'b0;
      else
         next_tx_flag = tx_flag;
      // live lock sets, so a write-one only clears once lock is gone
      next_lock_flag = lock_good | (lock_flag & ~(wr_cfg & pwdata[`FFC_B_LST]));
      next_rssi_src  = rssi_cross & cfg.rssi_en;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg             <= CFG_INIT;
         tx_flag         <= 1'b0;
         lock_flag       <= 1'b0;
         lock_good_d     <= 1'b0;
         rssi_irq_source <= 1'b0;
      end else begin
         cfg             <= next_cfg;
         tx_flag         <= next_tx_flag;
         lock_flag       <= next_lock_flag;
         lock_good_d     <= lock_good;
         rssi_irq_source <= next_rssi_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt block: sticky status, write-one clear, enable mask
   always_comb begin
      evt.tx_done   = tx_last_bit_out;
      evt.fill_done = fifo_fill_active & fill_complete;
      evt.lock      = lock_good & ~lock_good_d;
      evt.rssi      = next_rssi_src;
      next_status   = status;
      next_enable   = enable;
      if (wr && pstrb[0] && decode(paddr) == ffc_pkg::SEL_CLR)
         next_status = status & ~ffc_pkg::ffc_evt_s'(pwdata[3:0]);
      if (wr && pstrb[0] && decode(paddr) == ffc_pkg::SEL_EN)
         next_enable = ffc_pkg::ffc_evt_s'(pwdata[3:0]);
      // set wins over a clear in the same cycle
      next_status = next_status | evt;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status <= `FFC_EVT_RST;
         enable <= `FFC_EVT_RST;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq    <= |(next_status & next_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, captured in the setup cycle
   always_comb begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (psel && !penable) begin
         next_pslverr = 1'b0;
         unique case (decode(paddr))
            ffc_pkg::SEL_CFG:  next_prdata = {24'h0, cfg_view};
            ffc_pkg::SEL_STAT: next_prdata = {28'h0, status};
            ffc_pkg::SEL_CLR:  next_prdata = 32'h0;
            ffc_pkg::SEL_EN:   next_prdata = {28'h0, enable};
            ffc_pkg::SEL_NONE: begin
               next_prdata  = 32'h0;
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   logic first_cycle;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         first_cycle <= 1'b1;
      else
         first_cycle <= 1'b0;
   end

   sequence s_auto_done;
      !cfg.fill_method && fifo_fill_active && fill_complete;
   endsequence
   sequence s_auto_sync;
      !cfg.fill_method && sync_word_seen;
   endsequence

   property p_auto_start;
      !cfg.fill_method && !fifo_fill_active && sync_word_seen |=> fifo_fill_active;
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("auto fill did not start");

   property p_manual_no_sync;
      cfg.fill_method && !fifo_fill_active && sync_word_seen && !wr_cfg |=> !fifo_fill_active;
   endproperty
   a_manual_no_sync: assert property (p_manual_no_sync) else $error("manual fill began on sync");

   property p_read_filling;
      psel && !penable && decode(paddr) == ffc_pkg::SEL_CFG && fifo_fill_active
         |=> prdata[`FFC_B_FSC];
   endproperty
   a_read_filling: assert property (p_read_filling) else $error("fill status read not one");

   property p_fill_stops;
      fifo_fill_active && fill_complete |=> !fifo_fill_active ##0 status.fill_done;
   endproperty
   a_fill_stops: assert property (p_fill_stops) else $error("fill did not stop");

   property p_manual_stop;
      cfg.fill_method && fifo_fill_active && wr_cfg && !pwdata[`FFC_B_FSC]
         |=> !fifo_fill_active;
   endproperty
   a_manual_stop: assert property (p_manual_stop) else $error("manual stop ignored");

   property p_tx_done;
      tx_begin && !tx_last_bit_out ##1 !tx_last_bit_out[*2] |-> !tx_flag;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("transmit flag set while busy");

   property p_tx_rise;
      tx_last_bit_out |=> tx_flag && status.tx_done;
   endproperty
   a_tx_rise: assert property (p_tx_rise) else $error("transmit flag missed");

   property p_reset_value;
      first_cycle |-> cfg_view == `FFC_CFG_RST;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("config reset value wrong");

   property p_rearm;
      s_auto_done ##1 s_auto_sync |=> fifo_fill_active;
   endproperty
   a_rearm: assert property (p_rearm) else $error("auto fill not re-armed");

   property p_lock_clear;
      lock_flag && wr_cfg && pwdata[`FFC_B_LST] && !lock_good |=> !lock_flag;
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock flag not cleared");

   property p_lock_off;
      !cfg.lock_en && !lock_flag |=> !lock_flag;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock seen while disabled");

   property p_rssi_gate;
      rssi_cross |=> rssi_irq_source == $past(cfg.rssi_en);
   endproperty
   a_rssi_gate: assert property (p_rssi_gate) else $error("rssi gating wrong");

endmodule

// ==== tb/ffc_radio_model.sv ====
/*
 behavioural model of the radio datapath that feeds the fill and transmit events.
 assumes the bench starts each transmission and the block reports filling on fifo_fill_active.
*/
`timescale 1ns/1ns
module ffc_radio_model #(
   parameter int FILL_LEN = 12,
   parameter int TX_LEN   = 10
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // from the block and the bench
   input  wire logic fifo_fill_active,
   input  wire logic tx_begin,
   // events back into the block
   output logic      fill_complete,
   output logic      tx_last_bit_out
);
   int fill_cnt;
   int tx_cnt;
   logic tx_busy;

   ////////////////////////////////////////////////////////////////////////////////
   // fifo fills only while the block says so; count restarts on every new fill
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fill_cnt      <= 0;
         fill_complete <= 1'b0;
      end else begin
         fill_complete <= fifo_fill_active && (fill_cnt == FILL_LEN - 1);
         if (!fifo_fill_active)
            fill_cnt <= 0;
         else if (fill_cnt < FILL_LEN)
            fill_cnt <= fill_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shift register empties TX_LEN cycles after a start; a new start restarts it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_cnt          <= 0;
         tx_busy         <= 1'b0;
         tx_last_bit_out <= 1'b0;
      end else begin
         tx_last_bit_out <= tx_busy && (tx_cnt == TX_LEN - 1);
         if (tx_begin) begin
            tx_busy <= 1'b1;
            tx_cnt  <= 0;
         end else if (tx_busy) begin
            tx_cnt  <= tx_cnt + 1;
            tx_busy <= (tx_cnt < TX_LEN - 1);
         end
      end
   end
endmodule

// ==== tb/test_fifo_fill_and_tx_status_ctrl.sv ====
/*
 self-checking bench for ffc_top: apb master, datapath model, one task per scenario.
 assumes zero-wait apb slave and registers at index * 4 byte addresses.
*/
`timescale 1ns/1ns
`include "ffc_map.svh"
module test_fifo_fill_and_tx_status_ctrl;
   localparam logic [7:0] A_CFG = {`FFC_CFG_IDX, 2'b00};
   localparam logic [7:0] A_ST  = {`FFC_STAT_IDX, 2'b00};
   localparam logic [7:0] A_CLR = {`FFC_CLR_IDX, 2'b00};
   localparam logic [7:0] A_EN  = {`FFC_EN_IDX, 2'b00};
   localparam logic [7:0] A_BAD = 8'h3c;

   // design signals
   logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [3:0]  pstrb, lane;
   logic [31:0] pwdata, prdata, rdata;
   logic        sync_word_seen, fill_complete, tx_begin, tx_last_bit_out;
   logic        rssi_cross, lock_detect_raw, fifo_fill_active, fill_method_select;
   logic        tx_start_on_first_irq_sel, lock_detect_enable, rssi_irq_source, irq;
   int          n_mismatch, checks;

   ffc_top #(.ADDR_W(8)) i_ffc_top (
      .clock(clock), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_word_seen(sync_word_seen), .fill_complete(fill_complete),
      .tx_begin(tx_begin), .tx_last_bit_out(tx_last_bit_out), .rssi_cross(rssi_cross),
      .lock_detect_raw(lock_detect_raw), .fifo_fill_active(fifo_fill_active),
      .fill_method_select(fill_method_select),
      .tx_start_on_first_irq_sel(tx_start_on_first_irq_sel),
      .lock_detect_enable(lock_detect_enable), .rssi_irq_source(rssi_irq_source), .irq(irq));

   ffc_radio_model #(.FILL_LEN(12), .TX_LEN(10)) i_ffc_radio_model (
      .clock(clock), .reset_n(reset_n), .fifo_fill_active(fifo_fill_active),
      .tx_begin(tx_begin), .fill_complete(fill_complete), .tx_last_bit_out(tx_last_bit_out));

   always #10 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic print_verdict();
      if (n_mismatch == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      pstrb   <= lane;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk("pready", 32'h1, {31'h0, pready});
      rdata = prdata;
      chk("pslverr", {31'h0, a == A_BAD}, {31'h0, pslverr});
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // one-cycle pulse on a datapath event: 0 sync, 1 tx start, 2 rssi
   task automatic pulse(input int k);
      @(posedge clock);
      case (k)
         0: sync_word_seen <= 1'b1;
         1: tx_begin <= 1'b1;
         default: rssi_cross <= 1'b1;
      endcase
      @(posedge clock);
      sync_word_seen <= 1'b0;
      tx_begin       <= 1'b0;
      rssi_cross     <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      apb(0, A_CFG, 0);
      chk("cfg reset", 32'h01, rdata);
      chk("lock enable out", 32'h1, {31'h0, lock_detect_enable});
      apb(0, A_BAD, 0);
      chk("unmapped read", 32'h0, rdata);
      // neither an unmapped write nor a write with lane 0 off may land
      apb(1, A_BAD, 32'hfe);
      lane = 4'h0;
      apb(1, A_CFG, 32'h9c);
      lane = 4'h1;
      apb(0, A_CFG, 0);
      chk("ignored writes", 32'h01, rdata);
      apb(1, A_CFG, 32'h1d);
      apb(0, A_CFG, 0);
      chk("cfg readback", 32'h1d, rdata);
      chk("tx irq sel out", 32'h1, {31'h0, tx_start_on_first_irq_sel});
      apb(1, A_CFG, 32'h01);
   endtask

   task automatic t_auto_fill();
      int n;
      pulse(0);
      chk("fill active", 32'h1, {31'h0, fifo_fill_active});
      apb(0, A_CFG, 0);
      chk("fill status", 32'h1, {31'h0, rdata[`FFC_B_FSC]});
      n = 0;
      while (fifo_fill_active !== 1'b0 && n < 40) begin
         cyc(1);
         n++;
      end
      apb(0, A_CFG, 0);
      chk("fill status done", 32'h0, {31'h0, rdata[`FFC_B_FSC]});
      apb(0, A_ST, 0);
      chk("status fill", 32'h2, rdata);
      pulse(0);
      chk("fill rearmed", 32'h1, {31'h0, fifo_fill_active});
      // a sync word in the cycle right after completion must start the next fill
      n = 0;
      while (fill_complete !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk("fill done seen", 32'h1, {31'h0, fill_complete});
      pulse(0);
      chk("fill rearmed at once", 32'h1, {31'h0, fifo_fill_active});
      cyc(20);
   endtask

   task automatic t_manual();
      apb(1, A_CFG, 32'h81);
      chk("method out", 32'h1, {31'h0, fill_method_select});
      pulse(0);
      chk("no auto fill", 32'h0, {31'h0, fifo_fill_active});
      apb(1, A_CFG, 32'hc1);
      chk("manual start", 32'h1, {31'h0, fifo_fill_active});
      apb(1, A_CFG, 32'h81);
      chk("manual stop", 32'h0, {31'h0, fifo_fill_active});
      apb(0, A_CFG, 0);
      chk("stopped status", 32'h0, {31'h0, rdata[`FFC_B_FSC]});
      apb(1, A_CFG, 32'h01);
   endtask

   task automatic t_tx();
      int n;
      apb(1, A_CLR, 32'hf);
      pulse(1);
      apb(0, A_CFG, 0);
      chk("tx in progress", 32'h0, {31'h0, rdata[`FFC_B_TXD]});
      n = 0;
      do begin
         apb(0, A_CFG, 0);
         n++;
      end while (rdata[`FFC_B_TXD] !== 1'b1 && n < 20);
      chk("tx done", 32'h1, {31'h0, rdata[`FFC_B_TXD]});
      apb(0, A_ST, 0);
      chk("status tx", 32'h1, rdata);
      apb(1, A_EN, 32'h1);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1, A_EN, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1, A_EN, 32'h1);
      apb(1, A_CLR, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(0, A_CLR, 0);
      chk("clear reads 0", 32'h0, rdata);
      pulse(1);
      apb(0, A_CFG, 0);
      chk("tx restart", 32'h0, {31'h0, rdata[`FFC_B_TXD]});
      cyc(15);
   endtask

   task automatic t_lock();
      @(posedge clock);
      lock_detect_raw <= 1'b1;
      cyc(6);
      apb(0, A_CFG, 0);
      chk("lock flag", 32'h1, {31'h0, rdata[`FFC_B_LST]});
      apb(1, A_CFG, 32'h03);
      apb(0, A_CFG, 0);
      chk("lock held", 32'h1, {31'h0, rdata[`FFC_B_LST]});
      @(posedge clock);
      lock_detect_raw <= 1'b0;
      cyc(6);
      apb(0, A_CFG, 0);
      chk("lock sticky", 32'h1, {31'h0, rdata[`FFC_B_LST]});
      apb(1, A_CFG, 32'h03);
      apb(0, A_CFG, 0);
      chk("lock cleared", 32'h0, {31'h0, rdata[`FFC_B_LST]});
      apb(0, A_ST, 0);
      chk("status lock", 32'h1, {31'h0, rdata[2]});
      apb(1, A_CFG, 32'h00);
      chk("lock en off", 32'h0, {31'h0, lock_detect_enable});
      @(posedge clock);
      lock_detect_raw <= 1'b1;
      cyc(6);
      apb(0, A_CFG, 0);
      chk("lock disabled", 32'h0, {31'h0, rdata[`FFC_B_LST]});
      // let the synchroniser drain before detection is enabled again
      @(posedge clock);
      lock_detect_raw <= 1'b0;
      cyc(6);
      apb(1, A_CFG, 32'h01);
   endtask

   task automatic t_rssi();
      pulse(2);
      chk("rssi gated", 32'h0, {31'h0, rssi_irq_source});
      apb(1, A_CFG, 32'h05);
      pulse(2);
      chk("rssi source", 32'h1, {31'h0, rssi_irq_source});
      apb(0, A_ST, 0);
      chk("status rssi", 32'h1, {31'h0, rdata[3]});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sync_word_seen, tx_begin, rssi_cross, lock_detect_raw} = '0;
      pstrb = 4'h1;
      lane = 4'h1;
      n_mismatch = 0;
      checks = 0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      t_auto_fill();
      t_manual();
      t_tx();
      t_lock();
      t_rssi();
      print_verdict();
   end

   // whole run is a few hundred cycles; a hang ends well before this
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
endmodule
